/* File: hdl/eipd_defines.svh */
// Offsets, field positions and reset values of the external pin detector
`ifndef EIPD_DEFINES_SVH
`define EIPD_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define EIPD_OFS_SENSE      8'h00
`define EIPD_OFS_LEVEL      8'h04
`define EIPD_OFS_FLAGS      8'h08
`define EIPD_OFS_ENABLE     8'h0C
`define EIPD_OFS_STATUS     8'h10
`define EIPD_OFS_EVT_STATUS 8'h14
`define EIPD_OFS_EVT_CLEAR  8'h18
`define EIPD_OFS_EVT_ENABLE 8'h1C

// ****************************************************************
// Reset values and field positions
// ****************************************************************
`define EIPD_RST16          16'h0000
`define EIPD_RST8           8'h00
`define EIPD_RST32          32'h0000_0000
`define EIPD_B0_HI          7
`define EIPD_B0_LO          0
`define EIPD_B1_HI          15
`define EIPD_B1_LO          8
`define EIPD_SEL_B0         0
`define EIPD_SEL_B1         1
`define EIPD_FIELD_W        2
`define EIPD_TOP_PIN        7
`define EIPD_TOP_HI         15
`define EIPD_TOP_LO         14
`define EIPD_UP_HI          31
`define EIPD_UP_LO          8

`endif

/* File: hdl/eipd_pkg.sv */
// Types shared by the external pin detector
package eipd_pkg;

  typedef enum logic [1:0] {
    SENSE_LOW  = 2'b00,
    SENSE_FALL = 2'b01,
    SENSE_RISE = 2'b10,
    SENSE_BOTH = 2'b11
  } eipd_sense_type;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } eipd_bus_state_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } eipd_wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } eipd_wb_rsp_type;

endpackage

/* File: hdl/eipd_top.sv */
// External interrupt pin detector with Wishbone register access
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`include "eipd_defines.svh"

// Overview of operation
// - Sense field 00 makes a low level on the general pin a request.
// - Sense 01 detects falling, 10 rising, 11 both edges on the pin.
// - One two-bit field per general pin; pin 7 at bits 15:14, pin 0 at 1:0.
// - Polarity bit per pin interrupt input: 0 low level, 1 high level requests.
// - Unused upper bits read as zero; software writes only zero there.
// - Request flag bits 7 to 0 report pending requests of pins 7 to 0.
// - In level mode the flag reads 1 while the pin is low, else 0.
// - In edge mode the flag sets and holds on the selected edge.
// - An edge flag clears on a 0 write only after it was read as 1.
// - An edge flag also clears when the CPU handles that pin's exception.
// - Per input enable bit: 0 blocks pin interrupt requests, 1 passes them.
// - All four registers are 16 bits and clear on reset and deep standby; here only sense is 16 bits, level, flags and enable hold 8.
// - Read-only status bit per pin interrupt input shows a present request.
module eipd_top #(
  parameter int PINS = 8
) (
  input  wire logic                     clock,
  input  wire logic                     rst_b,
  input  wire eipd_pkg::eipd_wb_req_type wb_req,
  output eipd_pkg::eipd_wb_rsp_type     wb_rsp,
  input  wire logic [PINS-1:0]          general_request_pin,
  input  wire logic [PINS-1:0]          pin_interrupt_input,
  input  wire logic                     deep_standby,
  input  wire logic [PINS-1:0]          exception_ack,
  output logic [PINS-1:0]               general_request,
  output logic [PINS-1:0]               pin_int_request,
  output logic                          irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [PINS-1:0]               gp_s1;
  logic [PINS-1:0]               gp_s2;
  logic [PINS-1:0]               gp_s3;
  logic [PINS-1:0]               gp_stable;
  logic [PINS-1:0]               pi_s1;
  logic [PINS-1:0]               pi_s2;
  logic [PINS-1:0]               pi_s3;
  logic [PINS-1:0]               pi_stable;
  logic [2*PINS-1:0]             irq_sense_config;
  logic [PINS-1:0]               pin_int_level_sense;
  logic [PINS-1:0]               pin_int_enable;
  logic [PINS-1:0]               pin_int_request_status;
  logic [PINS-1:0]               read_one_seen;
  logic [2*PINS-1:0]             evt_status;
  logic [2*PINS-1:0]             evt_enable;
  eipd_pkg::eipd_bus_state_type  bus_state;
  logic [PINS-1:0]               next_gp_stable;
  logic [PINS-1:0]               next_pi_stable;
  logic [PINS-1:0]               gp_rise;
  logic [PINS-1:0]               gp_fall;
  logic [PINS-1:0]               edge_hit;
  logic [PINS-1:0]               edge_mask;
  logic [PINS-1:0]               level_mask;
  logic [PINS-1:0]               clear_hit;
  logic [PINS-1:0]               exc_clr;
  logic [PINS-1:0]               next_pin_status;
  logic [2*PINS-1:0]             evt_set;
  logic [2*PINS-1:0]             evt_clr;
  logic [31:0]                   next_rdata;
  logic                          acc;
  logic                          wr;
  logic                          rd;
  logic                          flag_wr;

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [1:0] sense_of(input logic [2*PINS-1:0] cfg, input int idx);
    sense_of = cfg[idx*`EIPD_FIELD_W +: `EIPD_FIELD_W];
  endfunction

  function automatic logic sense_hit(input logic [1:0] mode, input logic rise, input logic fall);
    logic hit;
    hit = 1'b0;
    case (eipd_pkg::eipd_sense_type'(mode))
      eipd_pkg::SENSE_FALL: hit = fall;
      eipd_pkg::SENSE_RISE: hit = rise;
      eipd_pkg::SENSE_BOTH: hit = rise | fall;
      default:              hit = 1'b0;
    endcase
    sense_hit = hit;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wdat,
                                          input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[`EIPD_SEL_B0]) begin
      res[`EIPD_B0_HI:`EIPD_B0_LO] = wdat[`EIPD_B0_HI:`EIPD_B0_LO];
    end
    if (sel[`EIPD_SEL_B1]) begin
      res[`EIPD_B1_HI:`EIPD_B1_LO] = wdat[`EIPD_B1_HI:`EIPD_B1_LO];
    end
    merge16 = res;
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gp_s1     <= {PINS{1'b1}};
      gp_s2     <= {PINS{1'b1}};
      gp_s3     <= {PINS{1'b1}};
      gp_stable <= {PINS{1'b1}};
    end else begin
      gp_s1     <= general_request_pin;
      gp_s2     <= gp_s1;
      gp_s3     <= gp_s2;
      gp_stable <= next_gp_stable;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pi_s1     <= '0;
      pi_s2     <= '0;
      pi_s3     <= '0;
      pi_stable <= '0;
    end else begin
      pi_s1     <= pin_interrupt_input;
      pi_s2     <= pi_s1;
      pi_s3     <= pi_s2;
      pi_stable <= next_pi_stable;
    end
  end

  always_comb begin
    next_gp_stable = ((gp_s2 ~^ gp_s3) & gp_s3) | ((gp_s2 ^ gp_s3) & gp_stable);
    next_pi_stable = ((pi_s2 ~^ pi_s3) & pi_s3) | ((pi_s2 ^ pi_s3) & pi_stable);
    gp_rise        = next_gp_stable & ~gp_stable;
    gp_fall        = ~next_gp_stable & gp_stable;
    for (int i = 0; i < PINS; i++) begin
      edge_hit[i]   = sense_hit(sense_of(irq_sense_config, i), gp_rise[i], gp_fall[i]);
      level_mask[i] = (sense_of(irq_sense_config, i) == eipd_pkg::SENSE_LOW);
    end
    edge_mask       = ~level_mask;
    next_pin_status = ~(pi_stable ^ pin_int_level_sense);
    exc_clr         = exception_ack & edge_mask & ~edge_hit;
  end

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  // Ack one cycle after the request; writes land at the ack edge, read data is taken earlier
  always_comb begin
    acc       = wb_req.cyc & wb_req.stb & (bus_state == eipd_pkg::BUS_IDLE);
    wr        = wb_req.cyc & wb_req.stb & wb_req.we & (bus_state == eipd_pkg::BUS_ACK);
    rd        = acc & ~wb_req.we;
    flag_wr   = wr & (wb_req.adr == `EIPD_OFS_FLAGS) & wb_req.sel[`EIPD_SEL_B0];
    clear_hit = flag_wr ? (read_one_seen & edge_mask & ~wb_req.dat[PINS-1:0]) : '0;
    evt_clr   = '0;
    if (wr && (wb_req.adr == `EIPD_OFS_EVT_CLEAR)) begin
      evt_clr = merge16(`EIPD_RST16, wb_req.dat, wb_req.sel);
    end
    evt_set = {next_pin_status & pin_int_enable & ~pin_int_request, edge_hit};
  end

  always_comb begin
    next_rdata = `EIPD_RST32;
    if (wb_req.adr == `EIPD_OFS_SENSE) begin
      next_rdata[2*PINS-1:0] = irq_sense_config;
    end else if (wb_req.adr == `EIPD_OFS_LEVEL) begin
      next_rdata[PINS-1:0] = pin_int_level_sense;
    end else if (wb_req.adr == `EIPD_OFS_FLAGS) begin
      next_rdata[PINS-1:0] = general_request;
    end else if (wb_req.adr == `EIPD_OFS_ENABLE) begin
      next_rdata[PINS-1:0] = pin_int_enable;
    end else if (wb_req.adr == `EIPD_OFS_STATUS) begin
      next_rdata[PINS-1:0] = pin_int_request_status;
    end else if (wb_req.adr == `EIPD_OFS_EVT_STATUS) begin
      next_rdata[2*PINS-1:0] = evt_status;
    end else if (wb_req.adr == `EIPD_OFS_EVT_ENABLE) begin
      next_rdata[2*PINS-1:0] = evt_enable;
    end else begin
      next_rdata = `EIPD_RST32;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bus_state <= eipd_pkg::BUS_IDLE;
    end else begin
      case (bus_state)
        eipd_pkg::BUS_IDLE: begin
          if (acc) begin
            bus_state <= eipd_pkg::BUS_ACK;
          end
        end
        default: begin
          bus_state <= eipd_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wb_rsp <= '0;
    end else begin
      wb_rsp.ack <= acc;
      if (rd) begin
        wb_rsp.dat <= next_rdata;
      end
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_sense_config    <= `EIPD_RST16;
      pin_int_level_sense <= `EIPD_RST8;
      pin_int_enable      <= `EIPD_RST8;
      evt_enable          <= `EIPD_RST16;
    end else if (deep_standby) begin
      irq_sense_config    <= `EIPD_RST16;
      pin_int_level_sense <= `EIPD_RST8;
      pin_int_enable      <= `EIPD_RST8;
      evt_enable          <= `EIPD_RST16;
    end else if (wr) begin
      if (wb_req.adr == `EIPD_OFS_SENSE) begin
        irq_sense_config <= merge16(irq_sense_config, wb_req.dat, wb_req.sel);
      end else if (wb_req.adr == `EIPD_OFS_LEVEL && wb_req.sel[`EIPD_SEL_B0]) begin
        pin_int_level_sense <= wb_req.dat[PINS-1:0];
      end else if (wb_req.adr == `EIPD_OFS_ENABLE && wb_req.sel[`EIPD_SEL_B0]) begin
        pin_int_enable <= wb_req.dat[PINS-1:0];
      end else if (wb_req.adr == `EIPD_OFS_EVT_ENABLE) begin
        evt_enable <= merge16(evt_enable, wb_req.dat, wb_req.sel);
      end
    end
  end

  // ****************************************************************
  // General request flags
  // ****************************************************************
  // Read of a 1 arms the clear; any flag write with byte lane 0 selected disarms
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      read_one_seen <= '0;
    end else if (deep_standby || flag_wr) begin
      read_one_seen <= '0;
    end else if (rd && wb_req.adr == `EIPD_OFS_FLAGS) begin
      read_one_seen <= read_one_seen | (general_request & edge_mask);
    end
  end

  // New edge beats a clear in the same cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      general_request <= '0;
    end else if (deep_standby) begin
      general_request <= '0;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (level_mask[i]) begin
          general_request[i] <= ~next_gp_stable[i];
        end else if (edge_hit[i]) begin
          general_request[i] <= 1'b1;
        end else if (clear_hit[i] || exception_ack[i]) begin
          general_request[i] <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Pin interrupt status and gating
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_int_request_status <= '0;
      pin_int_request        <= '0;
    end else begin
      pin_int_request_status <= next_pin_status;
      pin_int_request        <= next_pin_status & pin_int_enable;
    end
  end

  // ****************************************************************
  // Event status and interrupt output
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      evt_status <= `EIPD_RST16;
      irq        <= 1'b0;
    end else begin
      evt_status <= (evt_status & ~evt_clr) | evt_set;
      irq        <= |(((evt_status & ~evt_clr) | evt_set) & evt_enable);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_bus_req;
    acc;
  endsequence

  sequence s_bus_answer;
    wb_rsp.ack ##1 !wb_rsp.ack;
  endsequence

  sequence s_flag_clear;
    flag_wr && (clear_hit != '0) && !deep_standby;
  endsequence

  a_bus_answer: assert property (s_bus_req |=> s_bus_answer)
    else $error("bus ack not a single cycle after request");

  a_level_follow: assert property (
    !$past(deep_standby) |-> ((general_request ^ ~$past(next_gp_stable)) & $past(level_mask)) == '0)
    else $error("level flag does not follow pin");

  a_edge_sets: assert property (
    (edge_hit != '0 && !deep_standby) |=> (general_request & $past(edge_hit)) == $past(edge_hit))
    else $error("edge did not set flag");

  a_top_field: assert property (
    (gp_fall[`EIPD_TOP_PIN] && irq_sense_config[`EIPD_TOP_HI:`EIPD_TOP_LO] == eipd_pkg::SENSE_FALL)
    |-> edge_hit[`EIPD_TOP_PIN])
    else $error("top pin field misplaced");

  a_read_clear: assert property (
    s_flag_clear |=> (general_request & $past(clear_hit & ~edge_hit)) == '0)
    else $error("armed zero write did not clear");

  a_no_blind_clear: assert property (
    (!deep_standby && exception_ack == '0) |=>
    (($past(general_request) & ~$past(read_one_seen) & $past(edge_mask)) & ~general_request) == '0)
    else $error("edge flag cleared without prior read");

  a_exc_clears: assert property (
    (exc_clr != '0 && !deep_standby) |=> (general_request & $past(exc_clr)) == '0)
    else $error("exception handling did not clear flag");

  a_enable_gate: assert property (
    ##1 pin_int_request == (pin_int_request_status & $past(pin_int_enable)))
    else $error("pin interrupt not gated by enable");

  a_upper_zero: assert property (
    (rd && wb_req.adr inside {`EIPD_OFS_LEVEL, `EIPD_OFS_FLAGS, `EIPD_OFS_ENABLE})
    |=> wb_rsp.dat[`EIPD_UP_HI:`EIPD_UP_LO] == '0)
    else $error("upper bits not zero");

  a_standby_clear: assert property (
    deep_standby |=> (irq_sense_config == '0 && general_request == '0 &&
                      pin_int_level_sense == '0 && pin_int_enable == '0))
    else $error("deep standby did not clear registers");

  a_sync_settle: assert property (
    (gp_stable != $past(gp_stable)) |-> (($past(gp_s2) ~^ $past(gp_s3)) | ~(gp_stable ^ $past(gp_stable))) == '1)
    else $error("pin change taken before stages agree");

  a_irq_level: assert property (
    (evt_status & evt_enable) != '0 |=> irq || $past(evt_clr) != '0)
    else $error("enabled event without interrupt");

endmodule

/* File: testbench/eipd_src_model.sv */
// Partner model: external pin sources and CPU exception acceptance
`timescale 1ns/10ps
module eipd_src_model #(
  parameter int PINS = 8
) (
  input  wire logic            clock,
  input  wire logic            rst_b,
  input  wire logic [PINS-1:0] gp_level,
  input  wire logic [PINS-1:0] pi_level,
  input  wire logic            cpu_take,
  input  wire logic [3:0]      cpu_delay,
  input  wire logic [PINS-1:0] general_request,
  output logic [PINS-1:0]      general_request_pin,
  output logic [PINS-1:0]      pin_interrupt_input,
  output logic [PINS-1:0]      exception_ack
);
  logic [3:0] wait_count;
  logic       busy;

  // ****************************************************************
  // Pin sources
  // ****************************************************************
  // General pins idle high, as with a pull-up
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      general_request_pin <= '1;
      pin_interrupt_input <= '0;
    end else begin
      general_request_pin <= gp_level;
      pin_interrupt_input <= pi_level;
    end
  end

  // ****************************************************************
  // CPU exception acceptance
  // ****************************************************************
  // Lowest pending request wins; delay lets the bench act slow or prompt
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy          <= 1'b0;
      wait_count    <= 4'h0;
      exception_ack <= '0;
    end else begin
      exception_ack <= '0;
      if (!busy && cpu_take && general_request != '0) begin
        busy       <= 1'b1;
        wait_count <= cpu_delay;
      end else if (busy && wait_count != 4'h0) begin
        wait_count <= wait_count - 4'h1;
      end else if (busy) begin
        exception_ack <= general_request & (~general_request + PINS'(1));
        busy          <= 1'b0;
      end
    end
  end
endmodule

/* File: testbench/eipd_top_tb.sv */
// Self-checking testbench of the external pin detector
`timescale 1ns/10ps
module eipd_top_tb;
  logic                      clock;
  logic                      rst_b;
  eipd_pkg::eipd_wb_req_type wb_req;
  eipd_pkg::eipd_wb_rsp_type wb_rsp;
  logic [7:0]                gp_pin;
  logic [7:0]                pi_pin;
  logic [7:0]                gp_level;
  logic [7:0]                pi_level;
  logic                      deep_standby;
  logic [7:0]                exception_ack;
  logic [7:0]                general_request;
  logic [7:0]                pin_int_request;
  logic                      irq;
  logic                      cpu_take;
  int                        checks;
  int                        fail_count;
  int                        cycles;

  eipd_top eipd_top_inst (.clock(clock), .rst_b(rst_b), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .general_request_pin(gp_pin), .pin_interrupt_input(pi_pin), .deep_standby(deep_standby),
    .exception_ack(exception_ack), .general_request(general_request),
    .pin_int_request(pin_int_request), .irq(irq));

  eipd_src_model eipd_src_model_inst (.clock(clock), .rst_b(rst_b), .gp_level(gp_level),
    .pi_level(pi_level), .cpu_take(cpu_take), .cpu_delay(4'h3), .general_request(general_request),
    .general_request_pin(gp_pin), .pin_interrupt_input(pi_pin), .exception_ack(exception_ack));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // No fixed latency assumed; only the cycle ceiling ends a wait
  task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h3, adr: a, dat: d};
    do @(posedge clock); while (wb_rsp.ack !== 1'b1);
    q = wb_rsp.dat;
    wb_req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_cycle(1'b0, a, 32'h0000_0000, q);
    check(name, q, exp);
  endtask

  // Pins pass three sync stages, so eight cycles is a safe settle time
  task automatic set_pin(input int p, input logic v);
    @(posedge clock);
    gp_level[p] <= v;
    repeat (8) @(posedge clock);
  endtask

  task automatic edge_case(input int p, input logic [1:0] m);
    wr(8'h00, 32'(m) << (2 * p));
    set_pin(p, 1'b0);
    rd_chk("flag on fall", 8'h08, 32'(m[0]) << p);
    wr(8'h08, 32'h0000_0000);
    rd_chk("flag cleared", 8'h08, 32'h0000_0000);
    set_pin(p, 1'b1);
    rd_chk("flag on rise", 8'h08, 32'(m[1]) << p);
    wr(8'h08, 32'h0000_0000);
    rd_chk("flag cleared", 8'h08, 32'h0000_0000);
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      stop_test;
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_b = 1'b0;
    wb_req = '0;
    gp_level = 8'hFF;
    pi_level = 8'h00;
    deep_standby = 1'b0;
    cpu_take = 1'b0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    rd_chk("sense reset", 8'h00, 32'h0000_0000);
    rd_chk("level reset", 8'h04, 32'h0000_0000);
    rd_chk("flags reset", 8'h08, 32'h0000_0000);
    rd_chk("enable reset", 8'h0C, 32'h0000_0000);
    check("irq reset", 32'(irq), 32'h0000_0000);
    wr(8'h00, 32'h0000_9C36);
    rd_chk("sense fields", 8'h00, 32'h0000_9C36);
    rd_chk("unmapped", 8'h20, 32'h0000_0000);
    wr(8'h00, 32'h0000_0000);
    set_pin(0, 1'b0);
    rd_chk("level low", 8'h08, 32'h0000_0001);
    check("request out", 32'(general_request), 32'h0000_0001);
    set_pin(0, 1'b1);
    rd_chk("level high", 8'h08, 32'h0000_0000);
    for (int m = 1; m < 4; m++) begin
      edge_case(m, 2'(m));
    end
    wr(8'h00, 32'h0000_4000);
    set_pin(7, 1'b0);
    rd_chk("top pin fall", 8'h08, 32'h0000_0080);
    set_pin(7, 1'b1);
    wr(8'h00, 32'h0000_0100);
    set_pin(4, 1'b0);
    wr(8'h08, 32'h0000_0000);
    rd_chk("no read no clear", 8'h08, 32'h0000_0010);
    wr(8'h08, 32'h0000_0010);
    rd_chk("one write", 8'h08, 32'h0000_0010);
    wr(8'h08, 32'h0000_0000);
    rd_chk("armed clear", 8'h08, 32'h0000_0000);
    set_pin(4, 1'b1);
    set_pin(4, 1'b0);
    @(posedge clock);
    cpu_take <= 1'b1;
    repeat (12) @(posedge clock);
    cpu_take <= 1'b0;
    rd_chk("exception clear", 8'h08, 32'h0000_0000);
    rd_chk("pin status low", 8'h10, 32'h0000_00FF);
    check("pin disabled", 32'(pin_int_request), 32'h0000_0000);
    wr(8'h0C, 32'h0000_0001);
    wr(8'h04, 32'h0000_00FE);
    rd_chk("pin status mixed", 8'h10, 32'h0000_0001);
    check("pin enabled", 32'(pin_int_request), 32'h0000_0001);
    @(posedge clock);
    pi_level <= 8'h06;
    repeat (8) @(posedge clock);
    rd_chk("pin status high", 8'h10, 32'h0000_0007);
    rd_chk("level readback", 8'h04, 32'h0000_00FE);
    rd_chk("enable readback", 8'h0C, 32'h0000_0001);
    wr(8'h18, 32'h0000_FFFF);
    wr(8'h1C, 32'h0000_0020);
    wr(8'h00, 32'h0000_0400);
    set_pin(5, 1'b0);
    check("irq raised", 32'(irq), 32'h0000_0001);
    rd_chk("event status", 8'h14, 32'h0000_0020);
    wr(8'h1C, 32'h0000_0000);
    // Interrupt output settles one edge after the write lands
    repeat (2) @(posedge clock);
    check("irq masked", 32'(irq), 32'h0000_0000);
    wr(8'h1C, 32'h0000_0020);
    repeat (2) @(posedge clock);
    check("irq unmasked", 32'(irq), 32'h0000_0001);
    wr(8'h18, 32'h0000_0020);
    repeat (2) @(posedge clock);
    check("irq cleared", 32'(irq), 32'h0000_0000);
    rd_chk("clear reads zero", 8'h18, 32'h0000_0000);
    @(posedge clock);
    deep_standby <= 1'b1;
    @(posedge clock);
    deep_standby <= 1'b0;
    rd_chk("standby sense", 8'h00, 32'h0000_0000);
    rd_chk("standby level", 8'h04, 32'h0000_0000);
    rd_chk("standby enable", 8'h0C, 32'h0000_0000);
    stop_test;
  end
endmodule
